// ===== hdl/ncp_parser.sv
`timescale 1ns/100ps
module ncp_parser
    import ncp_pkg::*;
#(
    parameter bit ALT_VARIANT = 1'b0,
    parameter logic [7:0] DATUM_DEFAULT = DATUM_WGS84
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [7:0] rx_data,
    input wire logic rx_valid,
    output logic rx_ready,
    output logic [NUM_MSG*8-1:0] msg_rate,
    output logic [NUM_MSG-1:0] msg_cksum_en,
    output logic query_pulse,
    output logic [2:0] query_msg,
    output logic store_pulse,
    output logic [2:0] store_msg,
    output logic restart_pulse,
    output logic [31:0] geo_lat,
    output logic geo_lat_north,
    output logic [31:0] geo_lon,
    output logic geo_lon_east,
    output logic [31:0] geo_alt,
    output logic [31:0] geo_osc_hz,
    output logic [31:0] geo_tow,
    output logic [15:0] geo_week,
    output logic [7:0] geo_chan,
    output logic geo_data_valid,
    output logic geo_clear_eph,
    output logic geo_clear_mem,
    output logic debug_on,
    output logic [7:0] datum_sel,
    output logic reject_pulse,
    output logic [7:0] diag_data,
    output logic diag_valid,
    input wire logic diag_ready
);
    typedef struct packed {
        ncp_state_e st;
        logic rdy;
        logic [7:0] xsum;
        logic [7:0] rx_ck;
        logic ck_fmt;
        logic [3:0] fidx;
        logic [31:0] acc;
        logic neg;
        logic frac;
        logic [2:0] cpos;
        logic pre_ok;
        logic fmt;
        logic [MAX_FIELDS-1:0][31:0] fld;
        logic [MAX_FIELDS-1:0] sgn;
        logic [7:0] dcode;
        logic [NUM_MSG-1:0][7:0] rate;
        logic [NUM_MSG-1:0] cks;
        logic qp;
        logic [2:0] qm;
        logic sp;
        logic [2:0] sm;
        logic rp;
        logic [31:0] lat, lon, alt, osc, tow;
        logic north, east;
        logic [15:0] week;
        logic [7:0] chan;
        logic dv, ce, cm;
        logic dbg;
        logic [7:0] datum;
        logic [31:0] osc_saved;
        logic osc_have;
        logic rej;
    } ncp_core_s;

    ncp_core_s s_q, s_d;
    ncp_strm_if #(.W(8)) diag_if ();

    function automatic ncp_core_s close_field(ncp_core_s s);
        ncp_core_s r;
        r = s;
        if (s.fidx < 4'(MAX_FIELDS)) begin
            r.fld[s.fidx] = s.neg ? 32'(-s.acc) : s.acc;
            r.sgn[s.fidx] = s.neg;
        end else begin
            r.fmt = 1'b1;
        end
        if (s.fidx != 4'hF) begin
            r.fidx = s.fidx + 4'h1;
        end
        r.acc = '0;
        r.neg = 1'b0;
        r.frac = 1'b0;
        return r;
    endfunction

    function automatic logic [4:0] hex_val(logic [7:0] c);
        logic [4:0] v;
        v = 5'h10;
        if (c >= CH_0 && c <= CH_9) begin
            v = {1'b0, 4'(c - CH_0)};
        end else if (c >= CH_UA && c <= CH_UF) begin
            v = {1'b0, 4'(c - CH_UA + 8'h0A)};
        end
        return v;
    endfunction

    logic [7:0] c;
    logic take, is_digit;
    logic [4:0] hv;
    logic [31:0] digit;
    logic bad_ck, bad_fmt, bad_range, unknown;

    assign c = rx_data;
    assign take = rx_valid && s_q.rdy;
    assign is_digit = (c >= CH_0) && (c <= CH_9);
    assign hv = hex_val(c);
    assign digit = {24'h00_0000, c} - {24'h00_0000, CH_0};

    // Sentence verdict, evaluated in the execute state
    always_comb begin
        bad_ck = s_q.ck_fmt || (s_q.rx_ck != s_q.xsum);
        bad_fmt = s_q.fmt || !s_q.pre_ok || (s_q.cpos != PREFIX_LEN);
        unknown = 1'b0;
        bad_range = 1'b0;
        case (s_q.fld[0])
            ID_RATE_QUERY: begin
                bad_fmt = bad_fmt || (s_q.fidx != NF_RATE_QUERY);
                bad_range = (s_q.fld[1] > MSG_VTG) || (s_q.fld[2] > MODE_QUERY)
                    || (s_q.fld[3] > RATE_MAX) || (s_q.fld[4] > FLAG_MAX);
            end
            ID_GEO_INIT: begin
                bad_fmt = bad_fmt || (s_q.fidx != NF_GEO_INIT);
                bad_range = (s_q.fld[6] > WEEK_MAX) || (s_q.fld[7] < CHAN_MIN)
                    || (s_q.fld[7] > CHAN_MAX) || (s_q.fld[8] > BYTE_MAX);
            end
            ID_DEBUG_SW: begin
                bad_fmt = bad_fmt || (s_q.fidx != NF_SINGLE);
                bad_range = (s_q.fld[1] > FLAG_MAX);
            end
            ID_DATUM_SEL: begin
                bad_fmt = bad_fmt || (s_q.fidx != NF_SINGLE);
                bad_range = (s_q.fld[1] > BYTE_MAX);
            end
            default: begin
                unknown = 1'b1;
            end
        endcase
    end

    always_comb begin
        s_d = s_q;
        s_d.qp = 1'b0;
        s_d.sp = 1'b0;
        s_d.rp = 1'b0;
        s_d.rej = 1'b0;
        if (take && c == CH_DOLLAR) begin
            s_d.st = ST_BODY;
            s_d.xsum = '0;
            s_d.fidx = '0;
            s_d.acc = '0;
            s_d.neg = 1'b0;
            s_d.frac = 1'b0;
            s_d.cpos = '0;
            s_d.pre_ok = 1'b1;
            s_d.fmt = 1'b0;
            s_d.ck_fmt = 1'b0;
            s_d.fld = '0;
            s_d.sgn = '0;
        end else begin
            case (s_q.st)
                ST_IDLE: begin
                end
                ST_BODY: begin
                    if (take) begin
                        if (c == CH_STAR) begin
                            s_d = close_field(s_q);
                            s_d.st = ST_CK_HI;
                        end else begin
                            s_d.xsum = s_q.xsum ^ c;
                            if (c == CH_COMMA) begin
                                s_d = close_field(s_d);
                            end else if (s_q.fidx == 4'h0 && s_q.cpos < PREFIX_LEN) begin
                                if (c != PREFIX[2'h3 - s_q.cpos[1:0]]) begin
                                    s_d.pre_ok = 1'b0;
                                end
                                s_d.cpos = s_q.cpos + 3'h1;
                            end else if (is_digit) begin
                                // Fraction digits are dropped: only whole units are kept
                                if (!s_q.frac) begin
                                    s_d.acc = 32'(s_q.acc * 32'h0000_000A + digit);
                                end
                            end else if (c == CH_MINUS && s_q.acc == '0 && !s_q.frac) begin
                                s_d.neg = 1'b1;
                            end else if (c == CH_DOT) begin
                                s_d.frac = 1'b1;
                            end else begin
                                s_d.fmt = 1'b1;
                            end
                        end
                    end
                end
                ST_CK_HI: begin
                    if (take) begin
                        s_d.rx_ck[7:4] = hv[3:0];
                        s_d.ck_fmt = hv[4];
                        s_d.st = ST_CK_LO;
                    end
                end
                ST_CK_LO: begin
                    if (take) begin
                        s_d.rx_ck[3:0] = hv[3:0];
                        s_d.ck_fmt = s_q.ck_fmt || hv[4];
                        s_d.st = ST_CR;
                    end
                end
                ST_CR: begin
                    if (take) begin
                        s_d.fmt = s_q.fmt || (c != CH_CR);
                        s_d.st = (c == CH_CR) ? ST_LF : ST_EXEC;
                    end
                end
                ST_LF: begin
                    if (take) begin
                        s_d.fmt = s_q.fmt || (c != CH_LF);
                        s_d.st = ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    s_d.st = ST_IDLE;
                    if (bad_ck || bad_fmt || unknown || bad_range) begin
                        s_d.rej = 1'b1;
                        if (bad_ck) begin
                            s_d.dcode = DG_CKSUM;
                        end else if (bad_fmt) begin
                            s_d.dcode = DG_FORMAT;
                        end else if (unknown) begin
                            s_d.dcode = DG_UNKNOWN;
                        end else begin
                            s_d.dcode = DG_RANGE;
                        end
                        if (s_q.dbg) begin
                            s_d.st = ST_DIAG;
                        end
                    end else begin
                        case (s_q.fld[0])
                            ID_RATE_QUERY: begin
                                s_d.cks[s_q.fld[1][2:0]] = s_q.fld[4][0];
                                s_d.sp = 1'b1;
                                s_d.sm = s_q.fld[1][2:0];
                                if (s_q.fld[2] == MODE_PERIODIC) begin
                                    s_d.rate[s_q.fld[1][2:0]] = s_q.fld[3][7:0];
                                end else begin
                                    s_d.qp = 1'b1;
                                    s_d.qm = s_q.fld[1][2:0];
                                end
                            end
                            ID_GEO_INIT: begin
                                s_d.lat = s_q.fld[1];
                                s_d.north = !s_q.sgn[1];
                                s_d.lon = s_q.fld[2];
                                s_d.east = !s_q.sgn[2];
                                s_d.alt = s_q.fld[3];
                                if (s_q.fld[4] != '0) begin
                                    s_d.osc = s_q.fld[4];
                                    s_d.osc_saved = s_q.fld[4];
                                    s_d.osc_have = 1'b1;
                                end else if (s_q.osc_have) begin
                                    s_d.osc = s_q.osc_saved;
                                end else begin
                                    s_d.osc = ALT_VARIANT ? OSC_DEF_ALT_HZ : OSC_DEF_BASE_HZ;
                                end
                                s_d.tow = s_q.fld[5];
                                s_d.week = s_q.fld[6][15:0];
                                s_d.chan = s_q.fld[7][7:0];
                                s_d.dv = s_q.fld[8][RST_VALID_BIT];
                                s_d.ce = s_q.fld[8][RST_EPH_BIT];
                                s_d.cm = s_q.fld[8][RST_MEM_BIT];
                                s_d.rp = 1'b1;
                            end
                            ID_DEBUG_SW: begin
                                s_d.dbg = s_q.fld[1][0];
                            end
                            default: begin
                                s_d.datum = s_q.fld[1][7:0];
                            end
                        endcase
                    end
                end
                ST_DIAG: begin
                    // Parser waits here while the diagnostic buffer is full
                    if (diag_if.ready) begin
                        s_d.st = ST_IDLE;
                    end
                end
                default: begin
                    s_d.st = ST_IDLE;
                end
            endcase
        end
        s_d.rdy = (s_d.st != ST_EXEC) && (s_d.st != ST_DIAG);
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            s_q <= '0;
            s_q.st <= ST_IDLE;
            s_q.rdy <= 1'b1;
            s_q.rate <= {NUM_MSG{RATE_RESET}};
            s_q.dbg <= 1'b0;
            s_q.datum <= DATUM_DEFAULT;
        end else begin
            s_q <= s_d;
        end
    end

    assign diag_if.data = s_q.dcode;
    assign diag_if.valid = (s_q.st == ST_DIAG);

    ncp_buf #(.W(8)) u_diag_buf (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .up(diag_if.snk),
        .out_data(diag_data),
        .out_valid(diag_valid),
        .out_ready(diag_ready)
    );

    assign rx_ready = s_q.rdy;
    assign msg_rate = s_q.rate;
    assign msg_cksum_en = s_q.cks;
    assign query_pulse = s_q.qp;
    assign query_msg = s_q.qm;
    assign store_pulse = s_q.sp;
    assign store_msg = s_q.sm;
    assign restart_pulse = s_q.rp;
    assign geo_lat = s_q.lat;
    assign geo_lat_north = s_q.north;
    assign geo_lon = s_q.lon;
    assign geo_lon_east = s_q.east;
    assign geo_alt = s_q.alt;
    assign geo_osc_hz = s_q.osc;
    assign geo_tow = s_q.tow;
    assign geo_week = s_q.week;
    assign geo_chan = s_q.chan;
    assign geo_data_valid = s_q.dv;
    assign geo_clear_eph = s_q.ce;
    assign geo_clear_mem = s_q.cm;
    assign debug_on = s_q.dbg;
    assign datum_sel = s_q.datum;
    assign reject_pulse = s_q.rej;
endmodule

// ===== hdl/ncp_pkg.sv
package ncp_pkg;
    // Sentence framing, sign, decimal point and hex digit characters
    localparam logic [7:0] CH_DOLLAR = 8'h24;
    localparam logic [7:0] CH_STAR = 8'h2A;
    localparam logic [7:0] CH_COMMA = 8'h2C;
    localparam logic [7:0] CH_MINUS = 8'h2D;
    localparam logic [7:0] CH_DOT = 8'h2E;
    localparam logic [7:0] CH_CR = 8'h0D;
    localparam logic [7:0] CH_LF = 8'h0A;
    localparam logic [7:0] CH_0 = 8'h30;
    localparam logic [7:0] CH_9 = 8'h39;
    localparam logic [7:0] CH_UA = 8'h41;
    localparam logic [7:0] CH_UF = 8'h46;
    // Proprietary prefix letters, first letter in the top byte
    localparam logic [3:0][7:0] PREFIX = 32'h5053_5246;
    localparam logic [2:0] PREFIX_LEN = 3'h4;

    // Command identifiers
    localparam logic [31:0] ID_RATE_QUERY = 32'h0000_0067;
    localparam logic [31:0] ID_GEO_INIT = 32'h0000_0068;
    localparam logic [31:0] ID_DEBUG_SW = 32'h0000_0069;
    localparam logic [31:0] ID_DATUM_SEL = 32'h0000_006A;

    // Fields per sentence, identifier counted as field 0
    localparam logic [3:0] NF_RATE_QUERY = 4'h5;
    localparam logic [3:0] NF_GEO_INIT = 4'h9;
    localparam logic [3:0] NF_SINGLE = 4'h2;
    localparam int MAX_FIELDS = 9;

    // Sentence selector codes, query modes and field limits
    localparam int NUM_MSG = 6;
    localparam logic [31:0] MSG_GGA = 32'h0000_0000;
    localparam logic [31:0] MSG_VTG = 32'h0000_0005;
    localparam logic [31:0] MODE_PERIODIC = 32'h0000_0000;
    localparam logic [31:0] MODE_QUERY = 32'h0000_0001;
    localparam logic [31:0] RATE_MAX = 32'h0000_00FF;
    localparam logic [31:0] FLAG_MAX = 32'h0000_0001;
    localparam logic [31:0] BYTE_MAX = 32'h0000_00FF;
    localparam logic [31:0] WEEK_MAX = 32'h0000_FFFF;
    localparam logic [31:0] CHAN_MIN = 32'h0000_0001;
    localparam logic [31:0] CHAN_MAX = 32'h0000_000C;

    // Restart mask bits
    localparam int RST_VALID_BIT = 0;
    localparam int RST_EPH_BIT = 1;
    localparam int RST_MEM_BIT = 2;

    // Oscillator defaults in Hz
    localparam logic [31:0] OSC_DEF_BASE_HZ = 32'h0001_24F8;
    localparam logic [31:0] OSC_DEF_ALT_HZ = 32'h0001_7318;

    // Reset values
    localparam logic [7:0] RATE_RESET = 8'h00;
    localparam logic [7:0] DATUM_WGS84 = 8'h00;

    // Diagnostic codes
    localparam logic [7:0] DG_CKSUM = 8'h01;
    localparam logic [7:0] DG_RANGE = 8'h02;
    localparam logic [7:0] DG_UNKNOWN = 8'h03;
    localparam logic [7:0] DG_FORMAT = 8'h04;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_BODY = 3'b001,
        ST_CK_HI = 3'b010,
        ST_CK_LO = 3'b011,
        ST_CR = 3'b100,
        ST_LF = 3'b101,
        ST_EXEC = 3'b110,
        ST_DIAG = 3'b111
    } ncp_state_e;
endpackage

// ===== hdl/ncp_strm_if.sv
`timescale 1ns/100ps
interface ncp_strm_if #(parameter int W = 8);
    logic [W-1:0] data;
    logic valid;
    logic ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface

// ===== hdl/ncp_buf.sv
`timescale 1ns/100ps
module ncp_buf #(
    parameter int W = 8
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    ncp_strm_if.snk up,
    output logic [W-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    typedef struct packed {
        logic [W-1:0] d0;
        logic [W-1:0] d1;
        logic [1:0] cnt;
    } ncp_buf_s;

    ncp_buf_s s_q, s_d;
    logic pop, push;

    assign out_data = s_q.d0;
    assign out_valid = (s_q.cnt != 2'h0);
    // Ready comes from the count flop, so the source sees a full buffer at once
    assign up.ready = (s_q.cnt != 2'h2);
    assign pop = out_valid && out_ready;
    assign push = up.valid && up.ready;

    always_comb begin
        s_d = s_q;
        if (pop) begin
            s_d.d0 = s_q.d1;
            s_d.cnt = s_q.cnt - 2'h1;
        end
        if (push) begin
            if (s_d.cnt == 2'h0) begin
                s_d.d0 = up.data;
            end else begin
                s_d.d1 = up.data;
            end
            s_d.cnt = s_d.cnt + 2'h1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule

// ===== bench/ncp_parser_props.sv
`timescale 1ns/100ps
module ncp_parser_chk
    import ncp_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic rx_ready,
    input wire logic [NUM_MSG*8-1:0] msg_rate,
    input wire logic [NUM_MSG-1:0] msg_cksum_en,
    input wire logic query_pulse,
    input wire logic [2:0] query_msg,
    input wire logic store_pulse,
    input wire logic [2:0] store_msg,
    input wire logic restart_pulse,
    input wire logic [7:0] geo_chan,
    input wire logic debug_on,
    input wire logic [7:0] datum_sel,
    input wire logic reject_pulse,
    input wire logic [7:0] diag_data,
    input wire logic diag_valid,
    input wire logic diag_ready
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    property p_reset_vals;
        $fell(sys_rst) |-> debug_on == 1'b0 && datum_sel == DATUM_WGS84 && msg_rate == '0;
    endproperty
    property p_reject_holds;
        reject_pulse |-> $stable(msg_rate) && $stable(msg_cksum_en) && $stable(debug_on)
            && $stable(datum_sel) && !store_pulse && !restart_pulse;
    endproperty
    // Only the byte of the stored selector may move
    property p_rate_store;
        $changed(msg_rate) |-> store_pulse
            && ((msg_rate ^ $past(msg_rate)) & ~(48'h0000_0000_00FF << (8 * store_msg))) == '0;
    endproperty
    property p_flag_store;
        $changed(msg_cksum_en) |-> store_pulse;
    endproperty
    property p_exec_gap;
        (store_pulse || restart_pulse || reject_pulse) |-> $past(rx_ready) == 1'b0;
    endproperty
    property p_query_store;
        query_pulse |-> store_pulse && store_msg == query_msg;
    endproperty
    property p_chan;
        restart_pulse |-> geo_chan >= 8'h01 && geo_chan <= 8'h0C;
    endproperty
    property p_diag_hold;
        diag_valid && !diag_ready |=> diag_valid && $stable(diag_data);
    endproperty
    property p_diag_new;
        reject_pulse && debug_on |=> diag_valid;
    endproperty
    property p_diag_src;
        $rose(diag_valid) |-> debug_on && $past(reject_pulse);
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("bad reset value");
    a_reject_holds: assert property (p_reject_holds) else $error("reject changed");
    a_rate_store: assert property (p_rate_store) else $error("rate change bad");
    a_flag_store: assert property (p_flag_store) else $error("flag change bad");
    a_exec_gap: assert property (p_exec_gap) else $error("no execute gap");
    a_query_store: assert property (p_query_store) else $error("query bad");
    a_chan: assert property (p_chan) else $error("channel count out of range");
    a_diag_hold: assert property (p_diag_hold) else $error("diag not held");
    a_diag_new: assert property (p_diag_new) else $error("diag missing");
    a_diag_src: assert property (p_diag_src) else $error("diag unexpected");
    c_store: cover property (store_pulse);
    c_restart: cover property (restart_pulse);
    c_diag: cover property (diag_valid && diag_ready);
endmodule

bind ncp_parser ncp_parser_chk u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .rx_ready(rx_ready), .msg_rate(msg_rate), .msg_cksum_en(msg_cksum_en),
    .query_pulse(query_pulse), .query_msg(query_msg), .store_pulse(store_pulse),
    .store_msg(store_msg), .restart_pulse(restart_pulse), .geo_chan(geo_chan),
    .debug_on(debug_on), .datum_sel(datum_sel), .reject_pulse(reject_pulse),
    .diag_data(diag_data), .diag_valid(diag_valid), .diag_ready(diag_ready));

// ===== bench/ncp_host_model.sv
`timescale 1ns/100ps
module ncp_host_model
    import ncp_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rx_ready,
    output logic [7:0] rx_data,
    output logic rx_valid
);
    int gap = 0;
    initial begin
        rx_data = 8'h00;
        rx_valid = 1'b0;
    end
    function automatic logic [7:0] hexc(input logic [3:0] n);
        return (n < 4'hA) ? CH_0 + 8'(n) : CH_UA + 8'(n) - 8'h0A;
    endfunction
    // Holds a byte until taken; a released line shows no stale byte
    task automatic put(input logic [7:0] b);
        logic ok;
        rx_data <= b;
        rx_valid <= 1'b1;
        do begin
            @(negedge ref_clk);
            ok = rx_ready;
            @(posedge ref_clk);
        end while (!ok);
        if (gap > 0) begin
            rx_valid <= 1'b0;
            rx_data <= ~b;
            repeat (gap) @(posedge ref_clk);
        end
    endtask
    // ck_flip corrupts the checksum on purpose
    task automatic send(input string body, input logic [7:0] ck_flip);
        logic [7:0] ck;
        logic [7:0] c;
        ck = 8'h00;
        put(CH_DOLLAR);
        for (int i = 3; i >= 0; i--) begin
            ck ^= PREFIX[i];
            put(PREFIX[i]);
        end
        for (int i = 0; i < body.len(); i++) begin
            c = body[i];
            ck ^= c;
            put(c);
        end
        ck ^= ck_flip;
        put(CH_STAR);
        put(hexc(ck[7:4]));
        put(hexc(ck[3:0]));
        put(CH_CR);
        put(CH_LF);
        if (gap == 0) begin
            rx_valid <= 1'b0;
            rx_data <= 8'hF5;
        end
    endtask
endmodule

// ===== bench/nmea_command_parser_tb_top.sv
`timescale 1ns/100ps
module nmea_command_parser_tb_top
    import ncp_pkg::*;
();
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic diag_ready = 1'b1;
    logic [7:0] rx_data, diag_data, datum_sel, geo_chan;
    logic rx_valid, rx_ready, query_pulse, store_pulse, restart_pulse, debug_on, reject_pulse;
    logic geo_lat_north, geo_lon_east, geo_data_valid, geo_clear_eph, geo_clear_mem, diag_valid;
    logic [NUM_MSG*8-1:0] msg_rate;
    logic [NUM_MSG-1:0] msg_cksum_en;
    logic [2:0] query_msg, store_msg;
    logic [31:0] geo_lat, geo_lon, geo_alt, geo_osc_hz, geo_tow;
    logic [15:0] geo_week;
    logic [7:0] dq[$];
    logic [62:0] snap;
    int n_errors = 0;
    int total_checks = 0;
    int n_store = 0;
    int n_restart = 0;
    int n_reject = 0;
    int n_query = 0;
    int k;
    string bad[8] = '{"103,06,00,01,01", "103,01,00,256,01", "103,01,02,01,01",
        "104,1,1,1,0,5,6,13,1", "104,1,1,1,0,5,6,0,1", "107,1", "105,2", "103,01,00,09,01"};
    ncp_host_model host (.ref_clk(ref_clk), .rx_ready(rx_ready), .rx_data(rx_data),
        .rx_valid(rx_valid));
    ncp_parser uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .rx_data(rx_data),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .msg_rate(msg_rate),
        .msg_cksum_en(msg_cksum_en), .query_pulse(query_pulse), .query_msg(query_msg),
        .store_pulse(store_pulse), .store_msg(store_msg), .restart_pulse(restart_pulse),
        .geo_lat(geo_lat), .geo_lat_north(geo_lat_north), .geo_lon(geo_lon),
        .geo_lon_east(geo_lon_east), .geo_alt(geo_alt), .geo_osc_hz(geo_osc_hz),
        .geo_tow(geo_tow), .geo_week(geo_week), .geo_chan(geo_chan),
        .geo_data_valid(geo_data_valid), .geo_clear_eph(geo_clear_eph),
        .geo_clear_mem(geo_clear_mem), .debug_on(debug_on), .datum_sel(datum_sel),
        .reject_pulse(reject_pulse), .diag_data(diag_data), .diag_valid(diag_valid),
        .diag_ready(diag_ready));
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        if (store_pulse === 1'b1) n_store++;
        if (restart_pulse === 1'b1) n_restart++;
        if (reject_pulse === 1'b1) n_reject++;
        if (query_pulse === 1'b1) n_query++;
        if (diag_valid === 1'b1 && diag_ready === 1'b1) dq.push_back(diag_data);
    end
    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Outputs settle two edges after LF; four give margin
    task automatic cmd(input string body, input logic [7:0] flip = 8'h00);
        host.send(body, flip);
        repeat (4) @(posedge ref_clk);
        #1;
    endtask
    task automatic do_reset;
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        repeat (12) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        #1;
        chk("reset", {1'b0, 55'h0, DATUM_WGS84}, {1'b0, msg_rate, msg_cksum_en, debug_on, datum_sel});
        chk("ready", 64'h1, 64'(rx_ready));
    endtask
    task automatic final_report;
        $display("Checks %0d, mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        #400_000;
        n_errors++;
        $display("Watchdog expired");
        final_report;
    end
    initial begin
        do_reset;
        cmd("104,1,1,1,0,5,6,12,1");
        chk("default osc", {OSC_DEF_BASE_HZ, 32'h1}, {geo_osc_hz, 32'(n_restart)});
        for (k = 0; k < NUM_MSG; k++) begin
            cmd($sformatf("103,%02d,00,%0d,%0d", k, k * 51, k % 2));
            chk("rate", 64'(k * 51), 64'(msg_rate[k*8 +: 8]));
            chk("flag", 64'(k % 2), 64'(msg_cksum_en[k]));
            chk("store", {32'(k), 32'(k + 1)}, {29'h0, store_msg, 32'(n_store)});
        end
        cmd("103,02,01,00,01");
        chk("query", {32'h2, 32'h1}, {29'h0, query_msg, 32'(n_query)});
        chk("query rate", 64'h66, 64'(msg_rate[23:16]));
        $display("Test rates done");
        for (k = 0; k < 8; k++) begin
            snap = {msg_rate, msg_cksum_en, debug_on, datum_sel};
            cmd(bad[k], (k == 7) ? 8'h01 : 8'h00);
            chk("rejects", 64'(k + 1), 64'(n_reject));
            chk("kept", 64'(snap), 64'({msg_rate, msg_cksum_en, debug_on, datum_sel}));
        end
        chk("no restart", 64'h1, 64'(n_restart));
        $display("Test rejects done");
        cmd("104,37.3875111,-121.97232,0,96000,237759,922,12,3");
        chk("lat", {32'h0000_0025, 32'h1}, {geo_lat, 31'h0, geo_lat_north});
        chk("lon", {32'hFFFF_FF87, 32'h0}, {geo_lon, 31'h0, geo_lon_east});
        chk("osc tow", {32'h0001_7700, 32'h0003_A0BF}, {geo_osc_hz, geo_tow});
        chk("wk ch mask", {37'h0, 16'h039A, 8'h0C, 3'b011}, {37'h0, geo_week, geo_chan,
            geo_clear_mem, geo_clear_eph, geo_data_valid});
        cmd("104,-1.5,2,-3,0,1,2,1,4");
        chk("alt osc", {32'hFFFF_FFFD, 32'h0001_7700}, {geo_alt, geo_osc_hz});
        chk("signs", {32'hFFFF_FFFF, 32'h1}, {geo_lat, 30'h0, geo_lat_north, geo_lon_east});
        chk("mask", {32'h3, 29'h0, 3'b100}, {32'(n_restart), 29'h0, geo_clear_mem,
            geo_clear_eph, geo_data_valid});
        $display("Test geo done");
        cmd("105,1");
        chk("debug on", 64'h1, 64'(debug_on));
        @(posedge ref_clk);
        diag_ready <= 1'b0;
        cmd("103,01,00,09,01", 8'h01);
        cmd("103,09,00,01,01");
        cmd("107,0");
        chk("stall", 64'h0, 64'(rx_ready));
        repeat (16) begin
            @(posedge ref_clk);
            diag_ready <= ~diag_ready;
        end
        @(posedge ref_clk);
        diag_ready <= 1'b1;
        repeat (4) @(posedge ref_clk);
        #1;
        chk("diag", {32'h3, 8'h0, DG_CKSUM, DG_RANGE, DG_UNKNOWN},
            {32'(dq.size()), 8'h0, dq[0], dq[1], dq[2]});
        cmd("105,0");
        cmd("103,01,00,09,01", 8'h01);
        chk("quiet", {32'h3, 30'h0, 2'b00}, {32'(dq.size()), 30'h0, diag_valid, debug_on});
        $display("Test debug done");
        host.put(CH_DOLLAR);
        host.put(PREFIX[3]);
        cmd("106,178");
        chk("datum", {32'hC, 32'hB2}, {32'(n_reject), 24'h0, datum_sel});
        cmd("105,1");
        do_reset;
        host.gap = 3;
        cmd("103,04,00,07,00");
        chk("slow rate", 64'h7, 64'(msg_rate[39:32]));
        $display("Test reset and slow host done");
        final_report;
    end
endmodule
